// ### src/ufl_device.sv
`timescale 1ns/1ns
// Behaviour
// - fifo_control write-only; reads give interrupt_ident
// - Deep variant: bits 5:4 pick 8/16/32/56
// - Empty slots above threshold raise interrupt; block-mode request too
// - Shallow variant ignores threshold select bits
// - Bit 3 selects block DMA, FIFO mode only
// - Single mode: requests follow held characters
// - Block mode: transmit request releases only when full
// - Bit 2 flushes transmit queue, not shifter
// - Bit 1 flushes receive queue, not shifter
// - Shift registers cleared only by master reset
// - Bit 0 enables both FIFOs, resets 0
// - Other bits ignored unless enable set
// - line_format_control reads back last write
// - Bit 7 selects divisor and alternate registers
// - Bit 6 holds serial output low
// - Break leaves transmitter sequencing running
// - Host pads and sequences break safely
// - Host may time break with transmitter
module ufl_device
  import ufl_pkg::*;
#(
  parameter bit DEEP = 1'b1 // 1: 64-location variant, 0: 16-location variant
)
(
  input wire logic pclk,
  input wire logic presetn,
  ufl_if.dev bus,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic serial_output
);
  // ============================================================
  // Control registers
  logic [7:0] fc_r;      // FIFO enable, DMA mode, threshold select
  logic [7:0] lc_r;      // line_format_control
  logic [7:0] div_lo_r, div_hi_r; // Divisor low and high halves
  logic [7:0] alt_r;     // alternate_function_reg
  logic [7:0] txq [0:63]; // Transmit queue storage
  logic [7:0] rxq [0:63]; // Receive queue storage
  logic [5:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r; // Queue write and read pointers
  logic [6:0] tx_cnt_r, rx_cnt_r; // Queue fill counts, up to 64
  ufl_tstate_t tstate_r;
  logic [9:0] shift_r;   // Transmit shift register
  logic [3:0] bit_r;     // Bit index in frame
  logic [15:0] baud_r;   // Cycles within one bit
  logic [7:0] rdata_r;
  logic txreq_n_r, rxreq_n_r, txint_r, serial_output_r; // Output flops
  // ============================================================
  // Decode
  logic divsel, fifo_en; // Divisor select and FIFO mode
  logic [6:0] cap;       // Locations usable now
  logic fc_wr, fc_go;    // fifo_control write; with enable, other bits land
  logic tx_push, tx_pop, tx_flush; // Transmit queue moves
  logic rx_push, rx_pop, rx_flush; // Receive queue moves
  logic tx_room, line;   // Room above threshold, unforced line level
  logic [15:0] div_m1;
  assign divsel = lc_r[UFL_LC_DIVSEL];
  assign fifo_en = fc_r[UFL_FC_EN];
  // Without FIFOs the queue acts as a single holding location
  assign cap = !fifo_en ? UFL_ONE : (DEEP ? UFL_DEEP_DEPTH : UFL_SHALLOW_DEPTH);
  assign fc_wr = bus.wr_en && bus.addr == UFL_A_FIFO && !divsel;
  assign fc_go = fc_wr && bus.wdata[UFL_FC_EN];
  assign tx_flush = fc_go && bus.wdata[UFL_FC_TXRST];
  assign rx_flush = fc_go && bus.wdata[UFL_FC_RXRST];
  assign tx_push = bus.wr_en && bus.addr == UFL_A_DATA && !divsel && tx_cnt_r < cap;
  assign tx_pop = tstate_r == UFL_T_IDLE && tx_cnt_r != 7'h00;
  assign rx_push = rx_valid && rx_cnt_r < cap;
  assign rx_pop = bus.rd_en && bus.addr == UFL_A_DATA && !divsel && rx_cnt_r != 7'h00;
  // Shallow variant: room means an empty queue whatever bits 5:4 say
  assign tx_room = DEEP ? ((cap - tx_cnt_r) > ufl_thresh(fc_r[5:4]))
    : (tx_cnt_r == 7'h00);
  // A zero divisor behaves as one so the shifter never stalls
  assign div_m1 = ({div_hi_r, div_lo_r} == 16'h0000) ? 16'h0000
    : {div_hi_r, div_lo_r} - 16'h0001;
  assign line = (tstate_r == UFL_T_SHIFT) ? shift_r[0] : 1'b1;
  // ============================================================
  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fc_r <= UFL_FC_RESET;
      lc_r <= UFL_LC_RESET;
      div_lo_r <= UFL_DIVLO_RESET;
      div_hi_r <= UFL_DIVHI_RESET;
      alt_r <= UFL_ALT_RESET;
    end
    else if (bus.wr_en)
    begin
      if (bus.addr == UFL_A_LINE)
        lc_r <= bus.wdata;
      else if (divsel && bus.addr == UFL_A_DATA)
        div_lo_r <= bus.wdata;
      else if (divsel && bus.addr == UFL_A_DIVHI)
        div_hi_r <= bus.wdata;
      else if (divsel && bus.addr == UFL_A_FIFO)
        alt_r <= bus.wdata;
      else if (fc_go)
      begin
        // Reset bits are not stored: they self-clear
        fc_r[UFL_FC_EN] <= 1'b1;
        fc_r[UFL_FC_DMA] <= bus.wdata[UFL_FC_DMA];
        if (DEEP)
          fc_r[5:4] <= bus.wdata[5:4];
      end
      else if (fc_wr)
        fc_r <= UFL_FC_RESET;
    end
  end
  // ============================================================
  // Queue storage, no reset needed on data
  always_ff @(posedge pclk)
  begin
    if (tx_push && !tx_flush)
      txq[tx_wp_r] <= bus.wdata;
    if (rx_push && !rx_flush)
      rxq[rx_wp_r] <= rx_data;
  end
  // ============================================================
  // Transmit queue pointers; flush beats push and pop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_r <= 6'h00;
      tx_rp_r <= 6'h00;
      tx_cnt_r <= 7'h00;
    end
    else if (tx_flush)
    begin
      tx_wp_r <= 6'h00;
      tx_rp_r <= 6'h00;
      tx_cnt_r <= 7'h00;
    end
    else
    begin
      if (tx_push)
        tx_wp_r <= tx_wp_r + 6'h01;
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 6'h01;
      tx_cnt_r <= tx_cnt_r + {6'h00, tx_push} - {6'h00, tx_pop};
    end
  end
  // ============================================================
  // Receive queue pointers; characters beyond capacity are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp_r <= 6'h00;
      rx_rp_r <= 6'h00;
      rx_cnt_r <= 7'h00;
    end
    else if (rx_flush)
    begin
      rx_wp_r <= 6'h00;
      rx_rp_r <= 6'h00;
      rx_cnt_r <= 7'h00;
    end
    else
    begin
      if (rx_push)
        rx_wp_r <= rx_wp_r + 6'h01;
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 6'h01;
      rx_cnt_r <= rx_cnt_r + {6'h00, rx_push} - {6'h00, rx_pop};
    end
  end
  // ============================================================
  // Transmit shifter, 8N1; only presetn clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tstate_r <= UFL_T_IDLE;
      shift_r <= 10'h3ff;
      bit_r <= 4'h0;
      baud_r <= 16'h0000;
    end
    else
    begin
      case (tstate_r)
        UFL_T_IDLE:
        begin
          if (tx_pop)
          begin
            shift_r <= {1'b1, txq[tx_rp_r], 1'b0};
            bit_r <= 4'h0;
            baud_r <= 16'h0000;
            tstate_r <= UFL_T_SHIFT;
          end
        end
        default:
        begin
          // Break does not pause this sequencing
          if (baud_r >= div_m1)
          begin
            baud_r <= 16'h0000;
            shift_r <= {1'b1, shift_r[9:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == UFL_FRAME_LAST)
              tstate_r <= UFL_T_IDLE;
          end
          else
            baud_r <= baud_r + 16'h0001;
        end
      endcase
    end
  end
  // ============================================================
  // Pin and request outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_output_r <= 1'b1;
      txreq_n_r <= 1'b0;
      rxreq_n_r <= 1'b1;
      txint_r <= 1'b1;
    end
    else
    begin
      serial_output_r <= lc_r[UFL_LC_BREAK] ? 1'b0 : line;
      // Trigger levels are outside this block, so block mode raises
      // the receive request at the first character as well
      rxreq_n_r <= (rx_cnt_r == 7'h00);
      txint_r <= fifo_en ? tx_room : (tx_cnt_r == 7'h00);
      if (fifo_en && fc_r[UFL_FC_DMA])
      begin
        if (tx_room)
          txreq_n_r <= 1'b0;
        else if (tx_cnt_r == cap)
          txreq_n_r <= 1'b1;
      end
      else
        txreq_n_r <= (tx_cnt_r != 7'h00);
    end
  end
  // ============================================================
  // Register reads, answered one cycle after rd_en
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_r <= 8'h00;
    else if (bus.rd_en)
    begin
      if (bus.addr == UFL_A_LINE)
        rdata_r <= lc_r;
      else if (divsel && bus.addr == UFL_A_DATA)
        rdata_r <= div_lo_r;
      else if (divsel && bus.addr == UFL_A_DIVHI)
        rdata_r <= div_hi_r;
      else if (divsel && bus.addr == UFL_A_FIFO)
        rdata_r <= alt_r;
      else if (bus.addr == UFL_A_FIFO)
        rdata_r <= (fifo_en ? UFL_ID_FIFOS : 8'h00) | (txint_r ? UFL_ID_TX : UFL_ID_NONE);
      else if (bus.addr == UFL_A_DATA)
        rdata_r <= (rx_cnt_r != 7'h00) ? rxq[rx_rp_r] : 8'h00;
      else if (bus.addr == UFL_A_LSTAT)
        rdata_r <= {1'b0, (tx_cnt_r == 7'h00 && tstate_r == UFL_T_IDLE),
          (tx_cnt_r == 7'h00), 4'h0, (rx_cnt_r != 7'h00)};
      else
        rdata_r <= 8'h00;
    end
  end
  assign bus.rdata = rdata_r;
  assign bus.transmit_request_out_n = txreq_n_r;
  assign bus.receive_request_out_n = rxreq_n_r;
  assign bus.tx_int = txint_r;
  assign serial_output = serial_output_r;
endmodule

// ### src/ufl_host.sv
`timescale 1ns/1ns
// ============================================================
// APB-driven controller that programs the channel
module ufl_host
  import ufl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  ufl_if.host bus
);
  ufl_hstate_t state_r;   // Command sequencer
  logic [2:0] addr_r;     // Channel address driven out
  logic [7:0] wdata_r;
  logic wr_en_r;
  logic rd_en_r;
  logic [7:0] rd_data_r;  // Last data read from channel
  logic [1:0] isr_r;      // Sticky events
  logic [1:0] imr_r;      // Event mask
  logic txint_d_r;        // Previous transmit interrupt level
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic setup;
  logic access;
  logic cmd_go;
  logic [1:0] isr_set;
  logic isr_clr;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  // Commands while busy are dropped; STATUS bit 0 shows busy
  assign cmd_go = access && pwrite && paddr == UFL_R_CMD && state_r == UFL_H_IDLE;
  assign isr_set = {bus.tx_int && !txint_d_r, state_r == UFL_H_WAIT};
  assign isr_clr = access && !pwrite && paddr == UFL_R_INT_STAT;

  // ============================================================
  // APB slave: no wait states, data staged in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && paddr != UFL_R_CMD && paddr != UFL_R_STATUS
        && paddr != UFL_R_INT_STAT && paddr != UFL_R_INT_MASK;
      if (setup && !pwrite && paddr == UFL_R_STATUS)
        prdata_r <= {13'h0000, bus.tx_int, bus.receive_request_out_n,
          bus.transmit_request_out_n, rd_data_r, 7'h00, state_r != UFL_H_IDLE};
      else if (setup && !pwrite && paddr == UFL_R_INT_STAT)
        prdata_r <= {30'h00000000, isr_r};
      else if (setup && !pwrite && paddr == UFL_R_INT_MASK)
        prdata_r <= {30'h00000000, imr_r};
      else
        prdata_r <= 32'h00000000;
    end
  end

  // ============================================================
  // Mask register and sticky status; set wins over read-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      imr_r <= 2'h0;
      isr_r <= 2'h0;
      txint_d_r <= 1'b1; // Matches tx_int in reset, so no false edge
      irq_r <= 1'b0;
    end
    else
    begin
      txint_d_r <= bus.tx_int;
      if (access && pwrite && paddr == UFL_R_INT_MASK)
        imr_r <= pwdata[1:0];
      isr_r <= (isr_clr ? 2'h0 : isr_r) | isr_set;
      irq_r <= |(isr_r & imr_r);
    end
  end

  // ============================================================
  // Command sequencer: strobe one cycle, then collect the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= UFL_H_IDLE;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
      wr_en_r <= 1'b0;
      rd_en_r <= 1'b0;
      rd_data_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        UFL_H_IDLE:
        begin
          if (cmd_go)
          begin
            // Software sets FIFO enable before, or with, other bits
            addr_r <= pwdata[UFL_CMD_ADDR +: 3];
            wdata_r <= pwdata[7:0];
            wr_en_r <= pwdata[UFL_CMD_WRITE];
            rd_en_r <= !pwdata[UFL_CMD_WRITE];
            state_r <= UFL_H_ISSUE;
          end
        end
        UFL_H_ISSUE:
        begin
          wr_en_r <= 1'b0;
          rd_en_r <= 1'b0;
          state_r <= UFL_H_WAIT;
        end
        default:
        begin
          if (!wr_en_r)
            rd_data_r <= bus.rdata;
          state_r <= UFL_H_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr_en = wr_en_r;
  assign bus.rd_en = rd_en_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
endmodule

// ### src/ufl_if.sv
`timescale 1ns/1ns
// ============================================================
// Parallel host port between controller and channel
interface ufl_if;
  logic [2:0] addr;         // Register address
  logic wr_en;              // One-cycle write strobe
  logic rd_en;              // One-cycle read strobe
  logic [7:0] wdata;        // Write data
  logic [7:0] rdata;        // Read data, valid the cycle after rd_en
  logic transmit_request_out_n; // Transmit DMA request, active low
  logic receive_request_out_n;  // Receive DMA request, active low
  logic tx_int;             // Transmit interrupt, active high
  modport dev (input addr, wr_en, rd_en, wdata,
    output rdata, transmit_request_out_n, receive_request_out_n, tx_int);
  modport host (output addr, wr_en, rd_en, wdata,
    input rdata, transmit_request_out_n, receive_request_out_n, tx_int);
endinterface

// ### src/ufl_pkg.sv
// ============================================================
// Shared constants for the FIFO and line control channel
package ufl_pkg;
  // ============================================================
  // Device register addresses on the parallel host port
  localparam logic [2:0] UFL_A_DATA = 3'h0;  // Holding/receive data, divisor low with select
  localparam logic [2:0] UFL_A_DIVHI = 3'h1; // Divisor high with select
  localparam logic [2:0] UFL_A_FIFO = 3'h2;  // fifo_control write, interrupt_ident read
  localparam logic [2:0] UFL_A_LINE = 3'h3;  // line_format_control
  localparam logic [2:0] UFL_A_LSTAT = 3'h5; // Line status (read only)
  // ============================================================
  // fifo_control and line_format_control fields
  localparam int UFL_FC_EN = 0;
  localparam int UFL_FC_RXRST = 1;
  localparam int UFL_FC_TXRST = 2;
  localparam int UFL_FC_DMA = 3;
  localparam int UFL_FC_THR = 4;
  localparam int UFL_LC_BREAK = 6;
  localparam int UFL_LC_DIVSEL = 7;
  localparam logic [7:0] UFL_FC_RESET = 8'h00;
  localparam logic [7:0] UFL_LC_RESET = 8'h00;
  localparam logic [7:0] UFL_DIVLO_RESET = 8'h01;
  localparam logic [7:0] UFL_DIVHI_RESET = 8'h00;
  localparam logic [7:0] UFL_ALT_RESET = 8'h00;
  // ============================================================
  // interrupt_ident codes and line status bits
  localparam logic [7:0] UFL_ID_NONE = 8'h01;
  localparam logic [7:0] UFL_ID_TX = 8'h02;
  localparam logic [7:0] UFL_ID_FIFOS = 8'hc0;
  localparam int UFL_LS_DR = 0;
  localparam int UFL_LS_HOLDING_EMPTY_FLAG = 5;
  localparam int UFL_LS_TRANSMITTER_EMPTY_FLAG = 6;
  // ============================================================
  // Queue geometry and frame
  localparam logic [6:0] UFL_DEEP_DEPTH = 7'h40;
  localparam logic [6:0] UFL_SHALLOW_DEPTH = 7'h10;
  localparam logic [6:0] UFL_ONE = 7'h01;
  localparam logic [3:0] UFL_FRAME_LAST = 4'h9; // Start, 8 data, stop
  // ============================================================
  // Host APB register map
  localparam logic [11:0] UFL_R_CMD = 12'h000;
  localparam logic [11:0] UFL_R_STATUS = 12'h004;
  localparam logic [11:0] UFL_R_INT_STAT = 12'h008;
  localparam logic [11:0] UFL_R_INT_MASK = 12'h00c;
  localparam int UFL_CMD_ADDR = 8;
  localparam int UFL_CMD_WRITE = 16;
  localparam int UFL_IS_DONE = 0;
  localparam int UFL_IS_TXREQ = 1;
  // ============================================================
  // State encodings
  typedef enum logic [1:0] {UFL_H_IDLE = 2'b00, UFL_H_ISSUE = 2'b01, UFL_H_WAIT = 2'b11}
    ufl_hstate_t;
  typedef enum logic {UFL_T_IDLE = 1'b0, UFL_T_SHIFT = 1'b1} ufl_tstate_t;

  // Transmit empty-space threshold from the two select bits
  function automatic logic [6:0] ufl_thresh(input logic [1:0] sel);
    logic [6:0] t;
    t = 7'h08;
    case (sel)
      2'b01: t = 7'h10;
      2'b10: t = 7'h20;
      2'b11: t = 7'h38;
      default: t = 7'h08;
    endcase
    return t;
  endfunction
endpackage

// ### tb/testbench.sv
`timescale 1ns/1ns
// ============================================================
// Controller and channel joined, driven over APB
module testbench
  import ufl_pkg::*;
  ;
  logic pclk = 1'b0; // 100 MHz
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, rx_valid, serial_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rx_data;
  logic [31:0] q; // Last APB read word
  logic err; // Last APB error flag
  logic [7:0] b; // Last channel read byte
  logic so_q = 1'b1; // Serial output one cycle back
  int nfall = 0; // Start bits seen; idle high makes each one a falling edge
  int base; // nfall at the start of a scenario
  int n_mismatch = 0;
  int checks = 0;
  int thr[4] = '{8, 16, 32, 56}; // Empty-space thresholds by select code
  ufl_if i_ufl_if();
  ufl_host i_ufl_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus(i_ufl_if.host));
  ufl_device #(.DEEP(1'b1)) i_ufl_device(.pclk(pclk), .presetn(presetn), .bus(i_ufl_if.dev),
    .rx_valid(rx_valid), .rx_data(rx_data), .serial_output(serial_output));
  ufl_sva i_ufl_sva(.pclk(pclk), .presetn(presetn), .addr(i_ufl_if.addr),
    .wr_en(i_ufl_if.wr_en), .rd_en(i_ufl_if.rd_en), .wdata(i_ufl_if.wdata),
    .rdata(i_ufl_if.rdata), .transmit_request_out_n(i_ufl_if.transmit_request_out_n),
    .receive_request_out_n(i_ufl_if.receive_request_out_n), .tx_int(i_ufl_if.tx_int));
  // ============================================================
  // Clock and start-bit counter
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    so_q <= serial_output;
    if (so_q === 1'b1 && serial_output === 1'b0)
      nfall <= nfall + 1;
  end
  // ============================================================
  // Verdict, compare and bus tasks
  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    end_of_test();
  endtask
  // One transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      if (++n > 50)
        hang();
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, UFL_R_STATUS, 32'h0);
    chk(q & m, e);
  endtask
  // Channel command, then poll busy; busy stuck high shows as a hang
  task automatic chan(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, UFL_R_CMD, {15'h0, w, 5'h0, a, d});
    apb(1'b0, UFL_R_STATUS, 32'h0);
    while (q[0] !== 1'b0)
    begin
      if (++n > 50)
        hang();
      apb(1'b0, UFL_R_STATUS, 32'h0);
    end
    b = q[15:8];
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    chan(1'b0, a, 8'h00);
    chk({24'h0, b & m}, {24'h0, e});
  endtask
  // Long frames make this the slow wait; the bound covers one frame
  task automatic transmitter_empty_flag();
    int n;
    n = 0;
    chan(1'b0, UFL_A_LSTAT, 8'h00);
    while (b[UFL_LS_TRANSMITTER_EMPTY_FLAG] !== 1'b1)
    begin
      if (++n > 4000)
        hang();
      chan(1'b0, UFL_A_LSTAT, 8'h00);
    end
  endtask
  task automatic push(input logic [7:0] d);
    rx_valid <= 1'b1;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, rx_valid} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx_data = 8'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    stat(32'h0007_0001, 32'h0006_0000);
    rdc(UFL_A_FIFO, 8'hff, 8'h02);
    rdc(UFL_A_LINE, 8'hff, 8'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Done event masked, then unmasked, then cleared by reading
    chan(1'b1, UFL_A_LINE, 8'h1b);
    rdc(UFL_A_LINE, 8'hff, 8'h1b);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, UFL_R_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, UFL_R_INT_STAT, 32'h0);
    chk(q & 32'h3, 32'h1);
    apb(1'b0, UFL_R_INT_STAT, 32'h0);
    chk(q & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chan(1'b1, UFL_A_LINE, 8'h40);
    chk({31'h0, serial_output}, 32'h0);
    chan(1'b1, UFL_A_LINE, 8'h00);
    chk({31'h0, serial_output}, 32'h1);
    push(8'h3c);
    stat(32'h0002_0000, 32'h0);
    rdc(UFL_A_DATA, 8'hff, 8'h3c);
    stat(32'h0002_0000, 32'h0002_0000);
    // Block mode without enable is ignored, with enable taken at once
    chan(1'b1, UFL_A_FIFO, 8'h08);
    rdc(UFL_A_FIFO, 8'hc0, 8'h00);
    chan(1'b1, UFL_A_FIFO, 8'h09);
    rdc(UFL_A_FIFO, 8'hc0, 8'hc0);
    // Select bit reroutes the shared addresses; divisor 0x0800
    chan(1'b1, UFL_A_LINE, 8'h80);
    chan(1'b1, UFL_A_FIFO, 8'h5a);
    rdc(UFL_A_FIFO, 8'hff, 8'h5a);
    chan(1'b1, UFL_A_DATA, 8'h00);
    chan(1'b1, UFL_A_DIVHI, 8'h08);
    chan(1'b1, UFL_A_LINE, 8'h00);
    rdc(UFL_A_FIFO, 8'hc0, 8'hc0);
    push(8'h11);
    push(8'h22);
    stat(32'h0002_0000, 32'h0);
    chan(1'b1, UFL_A_FIFO, 8'h03);
    rdc(UFL_A_LSTAT, 8'h61, 8'h60);
    stat(32'h0002_0000, 32'h0002_0000);
    // One long frame keeps the shifter busy while the queue fills
    base = nfall;
    chan(1'b1, UFL_A_DATA, 8'hff);
    for (int c = 0; c < 4; c++)
    begin
      chan(1'b1, UFL_A_FIFO, {2'h0, c[1:0], c == 3, 3'h5});
      repeat (63 - thr[c]) chan(1'b1, UFL_A_DATA, 8'hff);
      stat(32'h0004_0000, 32'h0004_0000);
      chan(1'b1, UFL_A_DATA, 8'hff);
      stat(32'h0005_0000, {15'h0, c != 3, 16'h0});
    end
    repeat (56) chan(1'b1, UFL_A_DATA, 8'hff);
    stat(32'h0005_0000, 32'h0001_0000);
    chan(1'b1, UFL_A_FIFO, 8'h05);
    rdc(UFL_A_LSTAT, 8'h60, 8'h20);
    transmitter_empty_flag();
    chk(nfall - base, 32'h1);
    // Pad goes to the shifter, then break covers the rest of its frame
    base = nfall;
    chan(1'b1, UFL_A_DATA, 8'h00);
    rdc(UFL_A_LSTAT, 8'h60, 8'h20);
    chan(1'b1, UFL_A_LINE, 8'h40);
    rdc(UFL_A_LSTAT, 8'h40, 8'h00);
    transmitter_empty_flag();
    chk({31'h0, serial_output}, 32'h0);
    chan(1'b1, UFL_A_LINE, 8'h00);
    chk(nfall - base, 32'h1);
    chk({31'h0, serial_output}, 32'h1);
    end_of_test();
  end
endmodule

// ### tb/ufl_sva.sv
`timescale 1ns/1ns
// ============================================================
// Checker on the channel port between controller and channel
module ufl_sva
  import ufl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic transmit_request_out_n,
  input wire logic receive_request_out_n,
  input wire logic tx_int
);
  logic [7:0] lc_r; // Shadow of line_format_control
  logic [2:0] fe_r; // FIFO enable over the last three cycles
  logic [2:0] blk_r; // Block DMA mode over the last three cycles
  logic fc_wr; // A fifo_control write on the port
  logic id_rd; // An interrupt_ident read on the port
  assign fc_wr = wr_en && addr == UFL_A_FIFO && !lc_r[UFL_LC_DIVSEL];
  assign id_rd = rd_en && addr == UFL_A_FIFO && !lc_r[UFL_LC_DIVSEL];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ============================================================
  // Shadow state; mode history lets a mode change settle first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lc_r <= UFL_LC_RESET;
      fe_r <= 3'h0;
      blk_r <= 3'h0;
    end
    else
    begin
      lc_r <= (wr_en && addr == UFL_A_LINE) ? wdata : lc_r;
      fe_r <= {fe_r[1:0], fc_wr ? wdata[UFL_FC_EN] : fe_r[0]};
      blk_r <= {blk_r[1:0], fc_wr ? (wdata[UFL_FC_EN] & wdata[UFL_FC_DMA]) : blk_r[0]};
    end
  end
  // ============================================================
  // Port contract and channel behaviour
  a_strobe_gap: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en) [*2]) // Spacing
    else $error("channel strobes too close");
  a_rdata_hold: assert property (!rd_en |=> $stable(rdata)) // Read data stands
    else $error("read data moved without a read");
  a_line_back: assert property (rd_en && addr == UFL_A_LINE |=> rdata == $past(lc_r))
    else $error("line register read back wrong");
  a_ident_fifo: assert property (id_rd |=> rdata[7:2] == {{2{$past(fe_r[0])}}, 4'h0})
    else $error("ident FIFO bits wrong");
  a_ident_tx: assert property (id_rd |=> rdata[1:0] == ($past(tx_int) ? 2'h2 : 2'h1))
    else $error("ident transmit bits wrong");
  a_plain_txreq: assert property (fe_r == 3'h0 |-> transmit_request_out_n == !tx_int)
    else $error("non-FIFO transmit request wrong");
  a_room_empty: assert property (
    fe_r == 3'h7 && blk_r == 3'h0 && !transmit_request_out_n |-> tx_int)
    else $error("empty queue without room interrupt");
  a_block_release: assert property (blk_r == 3'h7 && $rose(transmit_request_out_n) |-> !tx_int)
    else $error("block request released before full");
  a_ready_tracks: assert property (
    rd_en && addr == UFL_A_LSTAT |=> rdata[UFL_LS_DR] == !receive_request_out_n)
    else $error("receive request disagrees with data ready");
endmodule
